// ### hw/ptl_regs.vh
// Purpose: Shared constants of the PCI target with lock and fast back-to-back support
// Assumes: Included by bare name from the target and the bench
// Notes: Definitions only; no logic lives here
`ifndef PTL_REGS_VH
`define PTL_REGS_VH

// ==========================================================
// Bus command codes (C/BE# during the address phase)
`define PTL_CMD_MEM_RD 4'h6
`define PTL_CMD_MEM_WR 4'h7
`define PTL_CMD_RD_MULT 4'hC
`define PTL_CMD_RD_LINE 4'hE
`define PTL_CMD_WR_INV 4'hF

// ==========================================================
// Decode window parameter defaults (arbitrary neutral values)
`define PTL_BAR_BASE 32'h1000_0000
`define PTL_BAR_MASK 32'hFFFF_F000

// ==========================================================
// Buffer shape and address stepping
`define PTL_FIFO_DEPTH 8
`define PTL_FIFO_AW 3
`define PTL_ADDR_STEP 32'h0000_0004

`endif

// ### hw/ptl_ram.v
// Purpose: Small dual-port word store behind the write buffer
// Assumes: Single clock, write and read ports independent
// Notes: Read data comes out of a register, one cycle after the read request
`timescale 1ns/1ps

module ptl_ram #(
  parameter W = 68,
  parameter AW = 3
) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire ce_in,
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [W-1:0] wr_data_in,
  input wire rd_en_in,
  input wire [AW-1:0] rd_addr_in,
  output reg [W-1:0] rd_data_out
);

  // Storage array, no reset needed
  reg [W-1:0] mem_reg [0:(1<<AW)-1];

  // ==========================================================
  // Write port
  always @(posedge clk_sys_in) begin
    if (ce_in && wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  // ==========================================================
  // Registered read port; cleared so the output is defined from reset
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_data_out <= {W{1'b0}};
    end else if (ce_in && rd_en_in) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end

endmodule

// ### hw/ptl_fifo.v
// Purpose: Write-data buffer between the PCI side and the user side
// Assumes: Same clock on both sides; valid/ready handshakes
// Notes: Holds DEPTH words in the store plus one in the output register
`timescale 1ns/1ps

module ptl_fifo #(
  parameter W = 68,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire ce_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  output reg out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out,
  output wire [AW:0] level_out
);

  reg [AW-1:0] wptr_reg; // Next slot to write
  reg [AW-1:0] rptr_reg; // Next slot to read
  reg [AW:0] count_reg; // Words held in the store
  wire push; // Accepted input word
  wire pop; // Store word moved to output register

  // Full is honest: refused once DEPTH words sit in the store
  assign in_ready_out = (count_reg < DEPTH[AW:0]);
  assign push = in_valid_in && in_ready_out;
  // Refill the output register when it is empty or being drained
  assign pop = (count_reg != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);
  assign level_out = count_reg;

  // ==========================================================
  // Store instance; its read register is the output data
  ptl_ram #(.W(W), .AW(AW)) u_ram (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .wr_en_in(push),
    .wr_addr_in(wptr_reg),
    .wr_data_in(in_data_in),
    .rd_en_in(pop),
    .rd_addr_in(rptr_reg),
    .rd_data_out(out_data_out)
  );

  // ==========================================================
  // Pointers, count and output valid
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid_out <= 1'b0;
    end else if (ce_in) begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      // Simultaneous push and pop leave the count alone
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
      if (pop) begin
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
    end
  end

endmodule

// ### hw/ptl_target.v
// Purpose: PCI target with exclusive lock handling and same-target fast back-to-back writes
// Assumes: PCI pins are synchronous to clk_sys_in, so they are sampled without synchronisers
// Notes: Writes land in an 8-word buffer plus its output register; reads fetch words from the user side
`timescale 1ns/1ps
`include "ptl_regs.vh"

module ptl_target #(
  parameter [31:0] BAR_BASE = `PTL_BAR_BASE,
  parameter [31:0] BAR_MASK = `PTL_BAR_MASK,
  parameter DEPTH = `PTL_FIFO_DEPTH,
  parameter AW = `PTL_FIFO_AW
) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire ce_in,
  input wire pci_frame_n_in,
  input wire pci_irdy_n_in,
  input wire pci_lock_n_in,
  input wire [31:0] pci_ad_in,
  input wire [3:0] pci_cbe_n_in,
  output reg [31:0] pci_ad_out,
  output reg pci_ad_oe_out,
  output reg pci_trdy_n_out,
  output reg pci_trdy_oe_out,
  output reg pci_devsel_n_out,
  output reg pci_devsel_oe_out,
  output reg pci_stop_n_out,
  output reg pci_stop_oe_out,
  output wire wr_valid_out,
  input wire wr_ready_in,
  output wire [31:0] wr_addr_out,
  output wire [31:0] wr_data_out,
  output wire [3:0] wr_be_out,
  output reg [31:0] rd_addr_out,
  output reg rd_strobe_out,
  input wire [31:0] rd_data_in,
  output reg locked_out
);

  // ==========================================================
  // States
  localparam [2:0] S_IDLE = 3'b000; // Bus idle or someone else's cycle
  localparam [2:0] S_CLAIM = 3'b001; // Locked: wait one clock before claiming or retrying
  localparam [2:0] S_WDATA = 3'b010; // Write data phases
  localparam [2:0] S_RWAIT = 3'b011; // Read: fetch next word, TRDY# high
  localparam [2:0] S_RDATA = 3'b100; // Read: word on AD, TRDY# low
  localparam [2:0] S_RETRY = 3'b101; // STOP# without TRDY#
  localparam [2:0] S_TURN = 3'b110; // Signals driven high one clock, then released

  localparam FW = 68; // Buffer word: address, byte enables, data

  reg [2:0] state_reg; // Transaction state
  reg frame_q_reg; // FRAME# seen on the previous edge
  reg first_reg; // High on the clock right after our address phase
  reg cmd_wr_reg; // Current transaction is a write
  reg lock_cand_reg; // Current transaction belongs to the lock holder
  reg [31:0] addr_reg; // Running word address

  wire addr_phase; // FRAME# newly low: an address phase
  wire hit; // Address phase decodes to us
  wire xfer; // Data phase completes this edge
  wire push; // Write word goes into the buffer
  wire [AW:0] level; // Words held in the buffer
  wire space_next; // Room for one more word after this edge
  wire fifo_in_ready; // Buffer accept
  wire [FW-1:0] fifo_out; // Buffer head

  // ==========================================================
  // Memory command decode; only memory commands are claimed
  function ptl_is_cmd;
    input [3:0] cmd;
    begin
      ptl_is_cmd = (cmd == `PTL_CMD_MEM_RD) || (cmd == `PTL_CMD_MEM_WR) ||
        (cmd == `PTL_CMD_RD_MULT) || (cmd == `PTL_CMD_RD_LINE) ||
        (cmd == `PTL_CMD_WR_INV);
    end
  endfunction

  // Write commands carry a one in bit 0
  function ptl_is_wr;
    input [3:0] cmd;
    begin
      ptl_is_wr = cmd[0];
    end
  endfunction

  // ==========================================================
  // Address phase detection. A falling FRAME# is used rather than an idle
  // bus, so an address driven straight after our own last write data phase
  // is caught too. No idle-cycle check is made, which is only safe because
  // initiators skip the idle solely for a write followed by the same target.
  assign addr_phase = !pci_frame_n_in && frame_q_reg;
  assign hit = addr_phase && ptl_is_cmd(pci_cbe_n_in) &&
    (((pci_ad_in ^ BAR_BASE) & BAR_MASK) == 32'h0000_0000);

  assign xfer = ((state_reg == S_WDATA) || (state_reg == S_RDATA)) &&
    !pci_trdy_n_out && !pci_irdy_n_in;
  assign push = (state_reg == S_WDATA) && xfer;
  // Counting the incoming word but not the outgoing one keeps TRDY# safe
  assign space_next = (level + {{AW{1'b0}}, push}) < DEPTH[AW:0];

  // ==========================================================
  // Write buffer; a stalled user side backs up into TRDY# wait states
  ptl_fifo #(.W(FW), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in({addr_reg, ~pci_cbe_n_in, pci_ad_in}),
    .out_valid_out(wr_valid_out),
    .out_ready_in(wr_ready_in),
    .out_data_out(fifo_out),
    .level_out(level)
  );

  assign wr_addr_out = fifo_out[67:36];
  assign wr_be_out = fifo_out[35:32];
  assign wr_data_out = fifo_out[31:0];

  // ==========================================================
  // Target sequencer and lock tracking
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg <= S_IDLE;
      frame_q_reg <= 1'b1;
      first_reg <= 1'b0;
      cmd_wr_reg <= 1'b0;
      lock_cand_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      pci_ad_out <= 32'h0000_0000;
      pci_ad_oe_out <= 1'b0;
      pci_trdy_n_out <= 1'b1;
      pci_trdy_oe_out <= 1'b0;
      pci_devsel_n_out <= 1'b1;
      pci_devsel_oe_out <= 1'b0;
      pci_stop_n_out <= 1'b1;
      pci_stop_oe_out <= 1'b0;
      rd_addr_out <= 32'h0000_0000;
      rd_strobe_out <= 1'b0;
      locked_out <= 1'b0;
    end else if (ce_in) begin
      frame_q_reg <= pci_frame_n_in;
      first_reg <= 1'b0;
      rd_strobe_out <= 1'b0;
      rd_addr_out <= addr_reg;

      // LOCK# low on the clock after a read's address phase starts a lock
      if (first_reg && !pci_lock_n_in && !cmd_wr_reg) begin
        lock_cand_reg <= 1'b1;
      end
      // Both high together: the holder has given up the lock
      if (locked_out && pci_frame_n_in && pci_lock_n_in) begin
        locked_out <= 1'b0;
      end
      // Lock only sticks once a data phase really completes; set beats clear
      if (xfer && lock_cand_reg) begin
        locked_out <= 1'b1;
      end

      case (state_reg)
        S_IDLE, S_TURN: begin
          // Release the sustained signals after their one high clock
          pci_trdy_oe_out <= 1'b0;
          pci_devsel_oe_out <= 1'b0;
          pci_stop_oe_out <= 1'b0;
          state_reg <= S_IDLE;
          if (hit) begin
            addr_reg <= {pci_ad_in[31:2], 2'b00};
            // The fetch address must not lag addr_reg, or the first read word is stale
            rd_addr_out <= {pci_ad_in[31:2], 2'b00};
            cmd_wr_reg <= ptl_is_wr(pci_cbe_n_in);
            first_reg <= 1'b1;
            // Only the holder shows LOCK# high while locked; others find it held low
            lock_cand_reg <= locked_out && pci_lock_n_in;
            if (locked_out) begin
              // Owner or intruder is known now; the answer goes out next clock
              state_reg <= S_CLAIM;
            end else if (ptl_is_wr(pci_cbe_n_in)) begin
              state_reg <= S_WDATA;
              pci_devsel_n_out <= 1'b0;
              pci_devsel_oe_out <= 1'b1;
              pci_trdy_oe_out <= 1'b1;
              pci_stop_oe_out <= 1'b1;
              pci_trdy_n_out <= !space_next;
            end else begin
              // AD needs a turnaround clock before we drive it
              state_reg <= S_RWAIT;
              pci_devsel_n_out <= 1'b0;
              pci_devsel_oe_out <= 1'b1;
              pci_trdy_oe_out <= 1'b1;
              pci_stop_oe_out <= 1'b1;
              pci_trdy_n_out <= 1'b1;
            end
          end
        end

        S_CLAIM: begin
          pci_devsel_n_out <= 1'b0;
          pci_devsel_oe_out <= 1'b1;
          pci_trdy_oe_out <= 1'b1;
          pci_stop_oe_out <= 1'b1;
          if (lock_cand_reg) begin
            // Holder's access: served normally and the lock is kept
            lock_cand_reg <= 1'b1;
            if (cmd_wr_reg) begin
              state_reg <= S_WDATA;
              pci_trdy_n_out <= !space_next;
            end else begin
              state_reg <= S_RDATA;
              pci_ad_out <= rd_data_in;
              pci_ad_oe_out <= 1'b1;
              pci_trdy_n_out <= 1'b0;
              rd_strobe_out <= 1'b1;
            end
          end else begin
            // Anyone else is told to retry; no data moves
            state_reg <= S_RETRY;
            // The owner's LOCK# low must not arm a lock for an intruder
            lock_cand_reg <= 1'b0;
            pci_stop_n_out <= 1'b0;
            pci_trdy_n_out <= 1'b1;
          end
        end

        S_WDATA: begin
          if (xfer && pci_frame_n_in) begin
            // Last word latched: drive high, turn around next clock
            state_reg <= S_TURN;
            pci_trdy_n_out <= 1'b1;
            pci_devsel_n_out <= 1'b1;
          end else begin
            if (xfer) begin
              addr_reg <= addr_reg + `PTL_ADDR_STEP;
            end
            // Hold off while the buffer is full, resume once it drains
            pci_trdy_n_out <= !space_next;
          end
        end

        S_RWAIT: begin
          // rd_data_in answers the address shown during this clock
          state_reg <= S_RDATA;
          pci_ad_out <= rd_data_in;
          pci_ad_oe_out <= 1'b1;
          pci_trdy_n_out <= 1'b0;
          rd_strobe_out <= 1'b1;
        end

        S_RDATA: begin
          if (xfer && pci_frame_n_in) begin
            state_reg <= S_TURN;
            pci_trdy_n_out <= 1'b1;
            pci_devsel_n_out <= 1'b1;
            pci_ad_oe_out <= 1'b0;
          end else if (xfer) begin
            // Each further word costs one wait state for the fetch
            state_reg <= S_RWAIT;
            addr_reg <= addr_reg + `PTL_ADDR_STEP;
            // Next fetch address goes out now so rd_data_in is ready in S_RWAIT
            rd_addr_out <= addr_reg + `PTL_ADDR_STEP;
            pci_trdy_n_out <= 1'b1;
          end
        end

        S_RETRY: begin
          // STOP# stays until the initiator drops FRAME#
          if (pci_frame_n_in) begin
            state_reg <= S_TURN;
            pci_stop_n_out <= 1'b1;
            pci_devsel_n_out <= 1'b1;
          end
        end

        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ### dv/ptl_target_asserts.sv
// Purpose: Timing checks on the target's bus outputs and its lock flag
// Assumes: ce_in is held high by the bench, so no cycle is frozen
// Notes: Bound to the top module from the bench file
`timescale 1ns/1ps

module ptl_target_asserts (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic pci_frame_n_in,
  input wire logic pci_irdy_n_in,
  input wire logic pci_lock_n_in,
  input wire logic pci_trdy_n_out,
  input wire logic pci_devsel_n_out,
  input wire logic pci_stop_n_out,
  input wire logic pci_ad_oe_out,
  input wire logic locked_out
);
  // ==========================================
  // Clocking, one domain only
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // ==========================================
  // Termination: retry only, never an abort
  a_no_abort: assert property (!pci_stop_n_out |-> !pci_devsel_n_out)
    else $error("stop without devsel");
  a_retry_nodata: assert property (!pci_stop_n_out |-> pci_trdy_n_out)
    else $error("stop together with trdy");
  a_retry_hold: assert property (!pci_stop_n_out && !pci_frame_n_in |=> !pci_stop_n_out)
    else $error("stop dropped while frame low");

  // ==========================================
  // Data phases and turnaround
  a_trdy_claim: assert property (!pci_trdy_n_out |-> !pci_devsel_n_out)
    else $error("trdy without devsel");
  a_last_drop: assert property (!pci_trdy_n_out && !pci_irdy_n_in && pci_frame_n_in
    |=> pci_trdy_n_out && pci_devsel_n_out) else $error("no drop after last word");
  a_ad_claim: assert property (pci_ad_oe_out |-> !pci_devsel_n_out)
    else $error("ad driven outside claim");

  // ==========================================
  // Lock ownership
  a_lock_set: assert property ($rose(locked_out) |-> $past(!pci_lock_n_in)
    && $past(!pci_irdy_n_in) && $past(!pci_trdy_n_out)) else $error("lock set without data");
  a_lock_keep: assert property (locked_out && !pci_lock_n_in |=> locked_out)
    else $error("lock lost while held");
  a_lock_free: assert property (locked_out && pci_frame_n_in && pci_lock_n_in
    |=> !locked_out) else $error("lock not released");
  a_intruder_retry: assert property (locked_out && $fell(pci_frame_n_in) && !pci_lock_n_in
    |-> ##2 (pci_devsel_n_out || !pci_stop_n_out)) else $error("locked target served intruder");
  a_owner_served: assert property (locked_out && $fell(pci_frame_n_in) && pci_lock_n_in
    |-> ##2 pci_stop_n_out) else $error("lock holder was retried");

  // ==========================================
  // Main scenarios reached
  c_locked: cover property ($rose(locked_out));
  c_retry: cover property (!pci_stop_n_out);
  c_b2b: cover property (!pci_trdy_n_out && pci_frame_n_in ##1 !pci_frame_n_in);
endmodule

// ### dv/ptl_initiator.sv
// Purpose: Behavioural PCI initiator that drives the target's bus side
// Assumes: Changes its lines just after the falling clock edge
// Notes: Status 0 done, 1 retried, 2 not claimed, 3 hung
`timescale 1ns/1ps

module ptl_initiator (
  input wire logic clk_sys_in,
  input wire logic [31:0] ad_in,
  input wire logic trdy_n_in,
  input wire logic devsel_n_in,
  input wire logic stop_n_in,
  output logic frame_n_out,
  output logic irdy_n_out,
  output logic lock_n_out,
  output logic [31:0] ad_out,
  output logic [3:0] cbe_n_out
);
  logic [31:0] rx [16]; // Words read back
  logic hold_n; // Level the owner keeps on LOCK# between accesses

  // ==========================================
  // Idle bus at time zero
  initial begin
    frame_n_out = 1'b1;
    irdy_n_out = 1'b1;
    lock_n_out = 1'b1;
    hold_n = 1'b1;
    ad_out = 32'h0;
    cbe_n_out = 4'hF;
  end

  // One transaction; b2b skips the idle cycle after our own write
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input int n, input bit lk,
    input bit b2b, input logic [31:0] d0, output int st);
    int k;
    int t;
    k = 0;
    t = 0;
    st = 3;
    if (!b2b) begin
      @(negedge clk_sys_in);
      irdy_n_out = 1'b1;
      ad_out = ~ad_out; // Released bus must not keep its last value
    end
    @(negedge clk_sys_in);
    irdy_n_out = 1'b1;
    frame_n_out = 1'b0;
    lock_n_out = lk ? 1'b1 : hold_n;
    ad_out = a;
    cbe_n_out = c;
    @(negedge clk_sys_in);
    lock_n_out = lk ? 1'b0 : hold_n;
    irdy_n_out = 1'b0;
    frame_n_out = (n == 1);
    cbe_n_out = 4'h0;
    ad_out = c[0] ? d0 : ~a;
    while (st == 3 && t < 60) begin
      @(posedge clk_sys_in);
      t++;
      if (!trdy_n_in && !irdy_n_out) begin
        rx[k] = ad_in;
        k++;
        if (k == n) st = 0;
      end else if (!stop_n_in) st = 1;
      else if (devsel_n_in && t > 5) st = 2; // Gives up like a master abort
      if (st == 3) begin
        @(negedge clk_sys_in);
        frame_n_out = (k >= n - 1);
        ad_out = c[0] ? d0 + 32'(k) : ~ad_out;
      end
    end
    if (lk && st == 0) hold_n = 1'b0;
    if (st != 0) begin
      @(negedge clk_sys_in);
      frame_n_out = 1'b1;
      lock_n_out = hold_n; // Owner's level returns; intruder never pulls it low
    end
  endtask

  // Owner ends its lock with FRAME# already high
  task automatic unlock();
    @(negedge clk_sys_in);
    irdy_n_out = 1'b1;
    lock_n_out = 1'b1;
    hold_n = 1'b1;
  endtask
endmodule

// ### dv/ptl_target_tb.sv
// Purpose: Self-checking bench for the locking back-to-back PCI target
// Assumes: Inputs change on the falling edge; ce_in stays high
// Notes: User read data is the inverted fetch address
`timescale 1ns/1ps
`include "ptl_regs.vh"

module ptl_target_tb;
  localparam logic [31:0] B = `PTL_BAR_BASE;
  localparam logic [31:0] K = 32'h5A5A_0000; // Write data seed mixed with the address
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic wr_ready = 1'b1; // User side takes write words
  int error_cnt = 0;
  int check_count = 0;
  int stall = 0; // Read and write cycles held off by TRDY#
  int strb = 0; // Read fetch pulses seen
  int st;
  logic [67:0] q [$]; // Words seen on the user write port
  wire frame_n, irdy_n, lock_n, ad_oe, trdy_n, trdy_oe, devsel_n, devsel_oe;
  wire stop_n, stop_oe, wr_valid, rd_strobe, locked;
  wire [31:0] ini_ad, dut_ad, wr_addr, wr_data, rd_addr;
  wire [3:0] cbe_n, wr_be;
  wire [31:0] ad_w = ad_oe ? dut_ad : ini_ad;
  wire trdy_w = trdy_oe ? trdy_n : 1'b1; // Control lines have pull-ups
  wire devsel_w = devsel_oe ? devsel_n : 1'b1;
  wire stop_w = stop_oe ? stop_n : 1'b1;

  // ==========================================
  // Design and initiator
  ptl_target i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(1'b1),
    .pci_frame_n_in(frame_n), .pci_irdy_n_in(irdy_n), .pci_lock_n_in(lock_n),
    .pci_ad_in(ad_w), .pci_cbe_n_in(cbe_n), .pci_ad_out(dut_ad), .pci_ad_oe_out(ad_oe),
    .pci_trdy_n_out(trdy_n), .pci_trdy_oe_out(trdy_oe), .pci_devsel_n_out(devsel_n),
    .pci_devsel_oe_out(devsel_oe), .pci_stop_n_out(stop_n), .pci_stop_oe_out(stop_oe),
    .wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data), .wr_be_out(wr_be), .rd_addr_out(rd_addr),
    .rd_strobe_out(rd_strobe), .rd_data_in(~rd_addr), .locked_out(locked));
  ptl_initiator i_ini (.clk_sys_in(clk_sys_in), .ad_in(ad_w), .trdy_n_in(trdy_w),
    .devsel_n_in(devsel_w), .stop_n_in(stop_w), .frame_n_out(frame_n), .irdy_n_out(irdy_n),
    .lock_n_out(lock_n), .ad_out(ini_ad), .cbe_n_out(cbe_n));

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Collect user words and count held-off data phases
  always @(posedge clk_sys_in) begin
    if (wr_valid && wr_ready) q.push_back({wr_addr, wr_data, wr_be});
    if (!irdy_n && !devsel_w && trdy_w && stop_w) stall++;
    if (rd_strobe) strb++;
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic run(input logic [3:0] c, input logic [31:0] a, input int n, input bit lk,
    input bit b2b, input int exp);
    i_ini.xfer(c, a, n, lk, b2b, a ^ K, st);
    chk("status", 32'(exp), 32'(st));
    if (st == 3) wrap_up(); // A hung transfer ends the run
  endtask

  task automatic chk_words(input logic [31:0] a, input int n);
    logic [67:0] w;
    for (int t = 0; t < 50 && q.size() < n; t++) @(posedge clk_sys_in);
    if (q.size() < n) begin
      chk("word count", 32'(n), 32'(q.size()));
      wrap_up();
    end
    for (int i = 0; i < n; i++) begin
      w = q.pop_front();
      chk("wr addr", a + 32'(4 * i), w[67:36]);
      chk("wr data", (a ^ K) + 32'(i), w[35:4]);
      chk("wr be", 32'hF, {28'h0, w[3:0]});
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_b2b();
    run(`PTL_CMD_MEM_WR, B + 32'h40, 1, 0, 0, 0);
    run(`PTL_CMD_WR_INV, B + 32'h80, 3, 0, 1, 0);
    chk_words(B + 32'h40, 1);
    chk_words(B + 32'h80, 3);
  endtask

  task automatic t_fill();
    @(negedge clk_sys_in);
    wr_ready = 1'b0;
    stall = 0;
    fork
      run(`PTL_CMD_MEM_WR, B + 32'h100, 12, 0, 0, 0);
      begin
        repeat (30) @(negedge clk_sys_in);
        wr_ready = 1'b1;
      end
    join
    chk("stalled", 32'h1, 32'(stall > 0));
    chk_words(B + 32'h100, 12);
  endtask

  task automatic t_decode();
    logic [3:0] c [4] = '{`PTL_CMD_RD_LINE, `PTL_CMD_RD_MULT, 4'h2, `PTL_CMD_MEM_RD};
    logic [31:0] a [4] = '{B + 32'h20, B + 32'h24, B + 32'h28, B ^ 32'h0100_0000};
    strb = 0;
    for (int i = 0; i < 4; i++) begin
      run(c[i], a[i], 1, 0, 0, (i < 2) ? 0 : 2);
      if (i < 2) chk("rd data", ~a[i], i_ini.rx[0]);
    end
    chk("rd strobes", 32'h2, 32'(strb));
  endtask

  task automatic t_lock();
    run(`PTL_CMD_MEM_RD, B + 32'h10, 2, 1, 0, 0);
    #1;
    chk("rd word1", ~(B + 32'h14), i_ini.rx[1]);
    chk("locked", 32'h1, {31'h0, locked});
    run(`PTL_CMD_MEM_RD, B + 32'h10, 2, 0, 0, 1);
    chk("locked", 32'h1, {31'h0, locked});
    run(`PTL_CMD_RD_MULT, B + 32'h18, 1, 1, 0, 0);
    #1;
    chk("locked", 32'h1, {31'h0, locked});
    i_ini.unlock();
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("locked", 32'h0, {31'h0, locked});
    run(`PTL_CMD_MEM_RD, B + 32'h10, 1, 0, 0, 0);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (12) @(negedge clk_sys_in);
    reset_in = 1'b0;
    t_b2b();
    t_fill();
    t_decode();
    t_lock();
    wrap_up();
  end
endmodule

bind ptl_target ptl_target_asserts i_chk (.clk_sys_in, .reset_in, .pci_frame_n_in,
  .pci_irdy_n_in, .pci_lock_n_in, .pci_trdy_n_out, .pci_devsel_n_out, .pci_stop_n_out,
  .pci_ad_oe_out, .locked_out);
